/* include/irq_src_pkg.sv */
/*
 * constants shared by the external, key and address match interrupt block:
 * register offsets, field positions, reset values and clock prescale taps.
 * assumes a 32-bit AXI4-Lite register port with word-aligned registers.
 */
`default_nettype none
package irq_src_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_IRQ_ENABLE_POLARITY_IDX = 8'h98;
	localparam logic [7:0] TIMER_C_CONTROL_A_IDX       = 8'h9A;
	localparam logic [7:0] TIMER_C_CONTROL_B_IDX       = 8'h9B;
	localparam logic [7:0] IRQ_STATUS_IDX              = 8'hA0;
	localparam logic [7:0] MATCH_CONTROL_IDX           = 8'hA1;
	localparam logic [7:0] MATCH_ADDR0_IDX             = 8'hA2;
	localparam logic [7:0] MATCH_ADDR1_IDX             = 8'hA3;
	localparam logic [7:0] TIMER_COMPARE0_IDX          = 8'hA4;
	localparam logic [7:0] TIMER_COMPARE1_IDX          = 8'hA5;
	localparam int          ADDR_W                     = 10;
	localparam logic [7:0]  REG_RESET                  = 8'h00;
	localparam logic [1:0]  RESP_OKAY                  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR                = 2'h2;

	// ----------------------------------------------------------------
	// timer_c_control_a fields
	// ----------------------------------------------------------------
	localparam int CTA_RUN      = 0;
	localparam int CTA_SRC_LO   = 1;
	localparam int CTA_POL_LO   = 3;
	localparam int CTA_TIMING   = 6;
	localparam int CTA_INSWITCH = 7;

	// ----------------------------------------------------------------
	// timer_c_control_b fields
	// ----------------------------------------------------------------
	localparam int CTB_FILT_LO  = 0;
	localparam int CTB_RELOAD   = 2;
	localparam int CTB_CCSEL    = 3;
	localparam int CTB_M0_LO    = 4;
	localparam int CTB_M1_LO    = 6;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_DIV1   = 2'h0;
	localparam logic [1:0] SRC_DIV8   = 2'h1;
	localparam logic [1:0] SRC_DIV32  = 2'h2;
	localparam logic [1:0] SRC_FAST   = 2'h3;
	localparam logic [1:0] POL_RISE   = 2'h0;
	localparam logic [1:0] POL_FALL   = 2'h1;
	localparam logic [1:0] POL_BOTH   = 2'h2;
	localparam logic [1:0] FILT_NONE  = 2'h0;
	localparam logic [1:0] FILT_DIV1  = 2'h1;
	localparam logic [1:0] FILT_DIV8  = 2'h2;
	localparam logic [1:0] OUT_HOLD   = 2'h0;
	localparam logic [1:0] OUT_TOGGLE = 2'h1;
	localparam logic [1:0] OUT_LOW    = 2'h2;
	localparam int         FILT_MATCHES = 3;
	localparam int         KEY_PINS     = 4;
	localparam logic [4:0] PRESCALE_MASK8  = 5'h07;
	localparam logic [4:0] PRESCALE_MASK32 = 5'h1F;
	localparam logic [15:0] COUNT_CLEAR    = 16'h0000;
	localparam logic [19:0] RET_STEP_SHORT = 20'h00001;
	localparam logic [19:0] RET_STEP_LONG  = 20'h00002;
endpackage
`default_nettype wire

/* rtl/level_filter.sv */
/*
 * three-sample digital level filter with edge detect on the accepted level.
 * assumes sample_tick is a one-cycle strobe in the aclk domain.
 */
`default_nettype none
`timescale 1ns/1ps
module level_filter
(
	input  wire logic aclk,        // system clock
	input  wire logic aresetn,     // synchronous reset, low
	input  wire logic bypass,      // pass raw input straight through
	input  wire logic sample_tick, // sampling strobe
	input  wire logic raw_in,      // unfiltered level
	output logic      level,       // accepted level
	output logic      rise,        // accepted rising edge pulse
	output logic      fall         // accepted falling edge pulse
);
	logic [1:0] hist;
	logic       level_q;
	logic       agree;
	logic       next_level;

	// ----------------------------------------------------------------
	// acceptance
	// ----------------------------------------------------------------
	// accept only three equal samples in a row
	assign agree      = (hist[0] == raw_in) && (hist[1] == raw_in);
	assign next_level = bypass ? raw_in : ((sample_tick && agree) ? raw_in : level_q);
	assign level      = level_q;
	assign rise       = next_level && !level_q;
	assign fall       = !next_level && level_q;

	// sample history and held level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hist    <= 2'h0;
			level_q <= 1'b0;
		end
		else
		begin
			if (sample_tick)
				hist <= {hist[0], raw_in};
			level_q <= next_level;
		end
	end
endmodule
`default_nettype wire

/* rtl/key_edge_detect.sv */
/*
 * key input edge detection with per-pin enable and polarity and the
 * active-level lockout between pins. assumes synchronous key inputs.
 */
`default_nettype none
`timescale 1ns/1ps
module key_edge_detect
(
	input  wire logic       aclk,      // system clock
	input  wire logic       aresetn,   // synchronous reset, low
	input  wire logic [7:0] cfg,       // enable/polarity pairs
	input  wire logic [3:0] key_in,    // key pins
	output logic            key_event  // combined edge pulse
);
	logic [3:0] prev;
	logic [3:0] en;
	logic [3:0] pol;
	logic [3:0] active_now;
	logic [3:0] active_was;
	logic [3:0] hit;
	logic [3:0] held_other;

	// ----------------------------------------------------------------
	// per-pin decode
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < irq_src_pkg::KEY_PINS; i++)
		begin : g_pin
			assign en[i]  = cfg[2 * i];
			assign pol[i] = cfg[2 * i + 1];
			assign active_now[i] = en[i] && (key_in[i] == pol[i]);
			assign active_was[i] = en[i] && (prev[i] == pol[i]);
			assign hit[i] = active_now[i] && !active_was[i];
			// another enabled pin already resting at its active level
			assign held_other[i] = |(active_was & ~(4'h1 << i));
		end
	endgenerate

	// one shared event for all pins
	assign key_event = |(hit & ~held_other);

	// previous pin levels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prev <= 4'hF;
		else
			prev <= key_in;
	end
endmodule
`default_nettype wire

/* rtl/ext_key_addr_match_irq.sv */
/*
 * interrupt sources: third external line with filter and timer C control,
 * four key inputs, two address match channels; AXI4-Lite register port.
 * assumes synchronous pins, one clock, cpu sequencer acks requests.
 */
// Local design decision: the AXI4-Lite register port.
`default_nettype none
`timescale 1ns/1ps
module ext_key_addr_match_irq
(
	input  wire logic        aclk,           // system clock
	input  wire logic        aresetn,        // synchronous reset, low
	input  wire logic [9:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // write strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [9:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire logic        ext_irq_line_three, // external line pin
	input  wire logic        slow_osc_div_tick,  // slow oscillator /128
	input  wire logic        fast_osc_clock,     // fast oscillator tick
	input  wire logic [3:0]  key_in,         // key pins, zero to three
	input  wire logic [19:0] fetch_addr,     // next instruction address
	input  wire logic        fetch_valid,    // instruction about to run
	input  wire logic        fetch_short,    // 16-bit or listed short form
	input  wire logic        ext3_ack,       // cpu took external request
	input  wire logic        key_ack,        // cpu took key request
	input  wire logic        match_ack,      // cpu took match request
	output logic             ext3_request,   // external line request flag
	output logic             key_request,    // key request flag
	output logic             key_wakeup,     // wake from wait or stop
	output logic             match_request,  // address match request
	output logic [19:0]      match_return,   // return address to push
	output logic             compare_out_pin // compare output
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  ctl_a;
	logic [7:0]  ctl_b;
	logic [7:0]  key_cfg;
	logic [1:0]  match_en;
	logic [19:0] match_addr0;
	logic [19:0] match_addr1;
	logic [15:0] cmp0;
	logic [15:0] cmp1;
	logic [15:0] timer_count_value;
	logic [4:0]  prescale;
	logic        aw_held;
	logic        w_held;
	logic [9:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire       count_run_bit     = ctl_a[irq_src_pkg::CTA_RUN];
	wire [1:0] count_src         = ctl_a[irq_src_pkg::CTA_SRC_LO +: 2];
	wire [1:0] ext3_polarity     = ctl_a[irq_src_pkg::CTA_POL_LO +: 2];
	wire       ext3_timing_sel   = ctl_a[irq_src_pkg::CTA_TIMING];
	wire       ext3_input_switch = ctl_a[irq_src_pkg::CTA_INSWITCH];
	wire [1:0] ext3_filter_sel   = ctl_b[irq_src_pkg::CTB_FILT_LO +: 2];
	wire       reload_on_match1  = ctl_b[irq_src_pkg::CTB_RELOAD];
	wire       capture_compare_sel = ctl_b[irq_src_pkg::CTB_CCSEL];
	wire [1:0] match0_out_mode   = ctl_b[irq_src_pkg::CTB_M0_LO +: 2];
	wire [1:0] match1_out_mode   = ctl_b[irq_src_pkg::CTB_M1_LO +: 2];

	// ----------------------------------------------------------------
	// prescaler taps
	// ----------------------------------------------------------------
	wire sys_clock_undivided     = 1'b1;
	wire sys_clock_div_eight     = (prescale & irq_src_pkg::PRESCALE_MASK8) == 5'h00;
	wire sys_clock_div_thirtytwo = (prescale & irq_src_pkg::PRESCALE_MASK32) == 5'h00;

	// count clock tick selected by the count source field
	wire count_tick = (count_src == irq_src_pkg::SRC_DIV1)  ? sys_clock_undivided :
	                  (count_src == irq_src_pkg::SRC_DIV8)  ? sys_clock_div_eight :
	                  (count_src == irq_src_pkg::SRC_DIV32) ? sys_clock_div_thirtytwo :
	                  fast_osc_clock;

	// filter sampling tick
	wire filt_tick = (ext3_filter_sel == irq_src_pkg::FILT_DIV1) ? sys_clock_undivided :
	                 (ext3_filter_sel == irq_src_pkg::FILT_DIV8) ? sys_clock_div_eight :
	                 sys_clock_div_thirtytwo;
	wire filt_bypass = (ext3_filter_sel == irq_src_pkg::FILT_NONE);

	// ----------------------------------------------------------------
	// external line three source and edge
	// ----------------------------------------------------------------
	wire ext3_source = ext3_input_switch ? slow_osc_div_tick : ext_irq_line_three;
	wire ext3_rise;
	wire ext3_fall;

	level_filter u_filter
	(
		.aclk        (aclk),
		.aresetn     (aresetn),
		.bypass      (filt_bypass),
		.sample_tick (filt_tick),
		.raw_in      (ext3_source),
		.level       (),
		.rise        (ext3_rise),
		.fall        (ext3_fall)
	);

	// polarity selection; the unused code detects nothing
	wire ext3_edge = (ext3_polarity == irq_src_pkg::POL_RISE) ? ext3_rise :
	                 (ext3_polarity == irq_src_pkg::POL_FALL) ? ext3_fall :
	                 (ext3_polarity == irq_src_pkg::POL_BOTH) ? (ext3_rise || ext3_fall) : 1'b0;

	// immediate when timing bit set, compare mode, or filtered
	wire ext3_immediate = ext3_timing_sel || capture_compare_sel || !filt_bypass;
	logic ext3_pending;
	wire  ext3_fire = ext3_immediate ? ext3_edge : (count_tick && (ext3_pending || ext3_edge));

	// config rewrite of input switch, timing or polarity fields may raise the flag
	wire ctl_a_write;
	wire [7:0] ctl_a_new;
	wire ext3_cfg_change = ctl_a_write &&
		((ctl_a_new[7:6] != ctl_a[7:6]) || (ctl_a_new[4:3] != ctl_a[4:3])) && (ext3_source != 1'b0);

	// ----------------------------------------------------------------
	// timer C counter and compare output
	// ----------------------------------------------------------------
	wire match0 = capture_compare_sel && count_run_bit && count_tick && (timer_count_value == cmp0);
	wire match1 = count_run_bit && count_tick && (timer_count_value == cmp1);

	// compare output action for a match with a given mode
	function automatic logic out_next(input logic cur, input logic [1:0] mode);
		out_next = (mode == irq_src_pkg::OUT_HOLD)   ? cur :
		           (mode == irq_src_pkg::OUT_TOGGLE) ? !cur :
		           (mode == irq_src_pkg::OUT_LOW)    ? 1'b0 : 1'b1;
	endfunction

	wire out_after0 = match0 ? out_next(compare_out_pin, match0_out_mode) : compare_out_pin;
	wire out_after1 = (match1 && capture_compare_sel) ? out_next(out_after0, match1_out_mode) : out_after0;

	// counter step
	wire [15:0] next_count = (match1 && reload_on_match1) ? irq_src_pkg::COUNT_CLEAR :
	                         (count_run_bit && count_tick) ? 16'(timer_count_value + 16'h0001) :
	                         timer_count_value;

	// prescaler, count and compare output
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prescale          <= 5'h00;
			timer_count_value <= 16'h0000;
			compare_out_pin   <= 1'b0;
		end
		else
		begin
			prescale          <= 5'(prescale + 5'h01);
			timer_count_value <= next_count;
			compare_out_pin   <= out_after1;
		end
	end

	// ----------------------------------------------------------------
	// key inputs
	// ----------------------------------------------------------------
	wire key_event;

	key_edge_detect u_keys
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cfg       (key_cfg),
		.key_in    (key_in),
		.key_event (key_event)
	);

	// ----------------------------------------------------------------
	// address match
	// ----------------------------------------------------------------
	wire hit0 = match_en[0] && fetch_valid && (fetch_addr == match_addr0);
	wire hit1 = match_en[1] && fetch_valid && (fetch_addr == match_addr1);
	wire [19:0] hit_base = hit0 ? match_addr0 : match_addr1;
	wire [19:0] ret_addr = 20'(hit_base + (fetch_short ? irq_src_pkg::RET_STEP_LONG
	                                                   : irq_src_pkg::RET_STEP_SHORT));

	// request flags: set wins over acknowledge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext3_pending  <= 1'b0;
			ext3_request  <= 1'b0;
			key_request   <= 1'b0;
			key_wakeup    <= 1'b0;
			match_request <= 1'b0;
			match_return  <= 20'h00000;
		end
		else
		begin
			ext3_pending  <= ext3_immediate ? 1'b0 : ((ext3_pending || ext3_edge) && !count_tick);
			ext3_request  <= ext3_fire || ext3_cfg_change || (ext3_request && !ext3_ack);
			key_request   <= key_event || (key_request && !key_ack);
			key_wakeup    <= key_event;
			// no global enable or priority level gates this flag
			match_request <= hit0 || hit1 || (match_request && !match_ack);
			if (hit0 || hit1)
				match_return <= ret_addr;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	wire [9:0]  wa  = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wd  = w_held ? w_data : s_axi_wdata;
	wire [3:0]  ws  = w_held ? w_strb : s_axi_wstrb;
	wire        wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	wire [7:0]  widx  = wa[9:2];
	wire        wsel_key = wr_go && (widx == irq_src_pkg::KEY_IRQ_ENABLE_POLARITY_IDX);
	wire        wsel_a   = wr_go && (widx == irq_src_pkg::TIMER_C_CONTROL_A_IDX);
	wire        wsel_b   = wr_go && (widx == irq_src_pkg::TIMER_C_CONTROL_B_IDX);
	wire        wsel_me  = wr_go && (widx == irq_src_pkg::MATCH_CONTROL_IDX);
	wire        wsel_m0  = wr_go && (widx == irq_src_pkg::MATCH_ADDR0_IDX);
	wire        wsel_m1  = wr_go && (widx == irq_src_pkg::MATCH_ADDR1_IDX);
	wire        wsel_c0  = wr_go && (widx == irq_src_pkg::TIMER_COMPARE0_IDX);
	wire        wsel_c1  = wr_go && (widx == irq_src_pkg::TIMER_COMPARE1_IDX);
	wire        wmapped  = wsel_key || wsel_a || wsel_b || wsel_me || wsel_m0 || wsel_m1 || wsel_c0 || wsel_c1
	                       || (widx == irq_src_pkg::IRQ_STATUS_IDX);
	assign ctl_a_write = aw_held && w_held && wsel_a && ws[0]; // one strobe, at the commit
	assign ctl_a_new   = wd[7:0];

	// byte-lane merge for wide registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		for (int b = 0; b < 4; b++)
			merge[8 * b +: 8] = s[b] ? d[8 * b +: 8] : old[8 * b +: 8];
	endfunction

	// read decode
	wire [7:0]  ridx = s_axi_araddr[9:2];
	wire [31:0] rmux =
		(ridx == irq_src_pkg::KEY_IRQ_ENABLE_POLARITY_IDX) ? {24'h000000, key_cfg} :
		(ridx == irq_src_pkg::TIMER_C_CONTROL_A_IDX) ? {24'h000000, ctl_a} :
		(ridx == irq_src_pkg::TIMER_C_CONTROL_B_IDX) ? {24'h000000, ctl_b} :
		(ridx == irq_src_pkg::IRQ_STATUS_IDX) ? {28'h0000000, compare_out_pin, match_request, key_request, ext3_request} :
		(ridx == irq_src_pkg::MATCH_CONTROL_IDX) ? {30'h00000000, match_en} :
		(ridx == irq_src_pkg::MATCH_ADDR0_IDX) ? {12'h000, match_addr0} :
		(ridx == irq_src_pkg::MATCH_ADDR1_IDX) ? {12'h000, match_addr1} :
		(ridx == irq_src_pkg::TIMER_COMPARE0_IDX) ? {16'h0000, cmp0} :
		(ridx == irq_src_pkg::TIMER_COMPARE1_IDX) ? {16'h0000, cmp1} : 32'h00000000;
	wire rmapped = (ridx == irq_src_pkg::KEY_IRQ_ENABLE_POLARITY_IDX) || (ridx == irq_src_pkg::TIMER_C_CONTROL_A_IDX)
	            || (ridx == irq_src_pkg::TIMER_C_CONTROL_B_IDX) || (ridx == irq_src_pkg::IRQ_STATUS_IDX)
	            || (ridx == irq_src_pkg::MATCH_CONTROL_IDX) || (ridx == irq_src_pkg::MATCH_ADDR0_IDX)
	            || (ridx == irq_src_pkg::MATCH_ADDR1_IDX) || (ridx == irq_src_pkg::TIMER_COMPARE0_IDX)
	            || (ridx == irq_src_pkg::TIMER_COMPARE1_IDX);
	wire rd_go = s_axi_arvalid && s_axi_arready;

	// write channel holding and response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 10'h000;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= irq_src_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wmapped ? irq_src_pkg::RESP_OKAY : irq_src_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// register storage, written once both halves are held
	wire commit = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			key_cfg     <= irq_src_pkg::REG_RESET;
			ctl_a       <= irq_src_pkg::REG_RESET;
			ctl_b       <= irq_src_pkg::REG_RESET;
			match_en    <= 2'h0;
			match_addr0 <= 20'h00000;
			match_addr1 <= 20'h00000;
			cmp0        <= 16'hFFFF;
			cmp1        <= 16'hFFFF;
		end
		else if (commit && ws[0])
		begin
			if (wsel_key) key_cfg <= wd[7:0];
			if (wsel_a)   ctl_a   <= {wd[7:6], 1'b0, wd[4:0]};
			if (wsel_b)   ctl_b   <= wd[7:0];
			if (wsel_me)  match_en <= wd[1:0];
			if (wsel_m0)  match_addr0 <= 20'(merge({12'h000, match_addr0}, wd, ws));
			if (wsel_m1)  match_addr1 <= 20'(merge({12'h000, match_addr1}, wd, ws));
			if (wsel_c0)  cmp0 <= 16'(merge({16'h0000, cmp0}, wd, ws));
			if (wsel_c1)  cmp1 <= 16'(merge({16'h0000, cmp1}, wd, ws));
		end
	end

	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= irq_src_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rmux;
				s_axi_rresp  <= rmapped ? irq_src_pkg::RESP_OKAY : irq_src_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* tb/irq_src_sva.sv */
/* checker on the irq block ports; assumes bind into ext_key_addr_match_irq */
`timescale 1ns/1ps
`default_nettype none
module irq_src_sva(input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
	s_axi_arready, s_axi_rvalid, s_axi_rready, fetch_valid, fetch_short, match_ack, key_wakeup, key_request,
	match_request, input wire logic [1:0] s_axi_bresp, input wire logic [31:0] s_axi_rdata,
	input wire logic [19:0] fetch_addr, match_return);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_pulse_a: assert property (s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready) else $error("aw ready");
	ar_answer_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("b dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("r dropped");
	wake_flag_a: assert property (key_wakeup |-> key_request) else $error("wake no flag");
	match_cause_a: assert property ($rose(match_request) |-> $past(fetch_valid)) else $error("stray");
	match_ret_a: assert property ($rose(match_request) |-> match_return == $past(fetch_addr) +
		($past(fetch_short) ? 20'h00002 : 20'h00001)) else $error("bad return");
	match_clr_a: assert property (match_ack && !fetch_valid |=> !match_request) else $error("no clear");
	key_c: cover property (key_wakeup);
	match_c: cover property ($rose(match_request));
	err_c: cover property (s_axi_bvalid && s_axi_bresp == irq_src_pkg::RESP_SLVERR);
endmodule
bind ext_key_addr_match_irq irq_src_sva chk_u(.*);
`default_nettype wire

/* tb/cpu_partner.sv */
/* cpu sequencer stand-in: acks each sticky request once; slow answers one cycle in four */
`timescale 1ns/1ps
`default_nettype none
module cpu_partner(input wire logic aclk, aresetn, slow, ext3_request, key_request, match_request,
	output logic ext3_ack, key_ack, match_ack);
	logic [1:0] cnt;
	wire logic go = !slow || cnt == 2'h0;
	// one-cycle ack pulses
	always_ff @(posedge aclk)
	begin
		cnt <= aresetn ? cnt + 2'h1 : 2'h0;
		ext3_ack <= aresetn && go && ext3_request && !ext3_ack;
		key_ack <= aresetn && go && key_request && !key_ack;
		match_ack <= aresetn && go && match_request && !match_ack;
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* bench: registers, keys, match, external line; assumes cpu_partner and checker compiled */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow;
	logic ext_irq_line_three, slow_osc_div_tick, fast_osc_clock, fetch_valid, fetch_short;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, d;
	logic [3:0] s_axi_wstrb, key_in;
	logic [19:0] fetch_addr;
	logic [1:0] r;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext3_ack, key_ack, match_ack;
	wire logic ext3_request, key_request, key_wakeup, match_request, compare_out_pin;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [19:0] match_return;
	int miscompares = 0, n_tests = 0, wakes = 0, e3s = 0, b;
	typedef struct {logic [9:0] a; logic [31:0] w, q; logic [1:0] p;} row_t;
	row_t rows[4] = '{'{10'h260, 32'hA5, 32'hA5, 2'h0}, '{10'h268, 32'h2E, 32'h0E, 2'h0},
		'{10'h26C, 32'h3C, 32'h3C, 2'h0}, '{10'h3FC, 32'hFF, 32'h00, 2'h2}};
	ext_key_addr_match_irq dut_u(.*);
	cpu_partner cpu_u(.*);
	task automatic chk(input string n, input logic [31:0] e, s);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		logic ad = 0, wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		do
		begin
			@(posedge aclk);
			ad |= s_axi_awready; wd |= s_axi_wready; s_axi_awvalid <= !ad; s_axi_wvalid <= !wd;
		end while (!(ad && wd));
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// key wakeups and external acks seen
	always @(posedge aclk)
	begin
		wakes <= wakes + int'(key_wakeup === 1'b1);
		e3s <= e3s + int'(ext3_ack === 1'b1);
	end
	initial
	begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	initial
	begin
		#40000;
		miscompares++;
		tally_and_finish;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, slow} = 0;
		{ext_irq_line_three, slow_osc_div_tick, fast_osc_clock, fetch_valid, fetch_short} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_addr} = 0;
		s_axi_wstrb = 4'hF; key_in = 4'hF;
		cyc(4); aresetn <= 1;
		foreach (rows[i])
		begin
			rd(rows[i].a); chk("reset", 32'h0, d);
			wr(rows[i].a, rows[i].w); rd(rows[i].a);
			chk("read", rows[i].q, d);
			chk("resp", {30'h0, rows[i].p}, {30'h0, r});
		end
		wr(10'h260, 32'h05);
		key_in <= 4'hE; cyc(4); chk("key", 32'h1, 32'(wakes));
		key_in <= 4'hC; cyc(4); chk("lock", 32'h1, 32'(wakes));
		key_in <= 4'h8; cyc(4); chk("off", 32'h1, 32'(wakes));
		key_in <= 4'hF; wr(10'h260, 32'h03); key_in <= 4'hE; cyc(4); key_in <= 4'hF; cyc(4);
		chk("rise", 32'h2, 32'(wakes));
		wr(10'h284, 32'h01); wr(10'h288, 32'h01234);
		fetch_addr <= 20'h01234; fetch_short <= 1; fetch_valid <= 1; cyc(1); fetch_valid <= 0; cyc(3);
		chk("ret2", 32'h01236, {12'h0, match_return});
		fetch_short <= 0; fetch_valid <= 1; cyc(1); fetch_valid <= 0; cyc(3);
		chk("ret1", 32'h01235, {12'h0, match_return});
		slow <= 1; wr(10'h284, 32'h00); fetch_short <= 1; fetch_valid <= 1; cyc(1); fetch_valid <= 0; cyc(6);
		chk("off", 32'h01235, {12'h0, match_return});
		wr(10'h268, 32'h00); b = e3s;
		ext_irq_line_three <= 1; cyc(8); chk("e3", 32'(b + 1), 32'(e3s));
		ext_irq_line_three <= 0; cyc(8); chk("e3f", 32'(b + 1), 32'(e3s));
		wr(10'h26C, 32'h01);
		ext_irq_line_three <= 1; cyc(2); ext_irq_line_three <= 0; cyc(8);
		chk("glitch", 32'(b + 1), 32'(e3s));
		ext_irq_line_three <= 1; cyc(10); chk("filt", 32'(b + 2), 32'(e3s));
		wr(10'h268, 32'h08); cyc(8); chk("rewrite", 32'(b + 3), 32'(e3s));
		wr(10'h290, 32'h03); wr(10'h26C, 32'h18); wr(10'h268, 32'h09); cyc(8);
		chk("cmp", 32'h1, {31'h0, compare_out_pin});
		aresetn <= 0; cyc(2); aresetn <= 1; rd(10'h268); chk("rst", 32'h0, d);
		tally_and_finish;
	end
endmodule
`default_nettype wire
